/* File: verilog/ulfc_pkg.sv */
// line format settings, field layout and oversampling constants
// shared by the format control top and its baud tick divider
`default_nettype none
package ulfc_pkg;

	// -------------------------------------------------------------
	// line format register layout, msb first
	// -------------------------------------------------------------
	typedef struct packed {
		logic dlab;
		logic brk;
		logic force_par;
		logic even;
		logic par_en;
		logic stop_long;
		logic [1:0] wlen;
	} ulfc_fmt_t;

	localparam logic [7:0] ULFC_FMT_RESET = 8'h00;
	localparam int ULFC_DIV_W = 16;

	// -------------------------------------------------------------
	// oversampling, 16 ticks per bit time
	// -------------------------------------------------------------
	localparam logic [5:0] ULFC_OS_LAST = 6'h0f;
	localparam logic [5:0] ULFC_OS_MID = 6'h07;
	localparam logic [5:0] ULFC_OS_STOP1 = 6'h0f;
	localparam logic [5:0] ULFC_OS_STOP15 = 6'h17;
	localparam logic [5:0] ULFC_OS_STOP2 = 6'h1f;
	localparam logic [2:0] ULFC_WLEN_BASE = 3'h4;
	localparam logic [1:0] ULFC_WLEN5 = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP
	} ulfc_state_t;

	// index of the last data bit for a word length code
	function automatic logic [2:0] ulfc_last_bit(input logic [1:0] wl);
		ulfc_last_bit = ULFC_WLEN_BASE + {1'b0, wl};
	endfunction

	// parity bit for a character under the given format
	function automatic logic ulfc_parity(input ulfc_fmt_t f,
			input logic [7:0] d);
		logic [7:0] m;
		m = d & (8'hff >> (3'h3 - {1'b0, f.wlen}));
		if (f.force_par)
			ulfc_parity = ~f.even;
		else if (f.even)
			ulfc_parity = ^m;
		else
			ulfc_parity = ~^m;
	endfunction

	// last oversample count of the stop period
	function automatic logic [5:0] ulfc_stop_last(input ulfc_fmt_t f);
		if (!f.stop_long)
			ulfc_stop_last = ULFC_OS_STOP1;
		else if (f.wlen == ULFC_WLEN5)
			ulfc_stop_last = ULFC_OS_STOP15;
		else
			ulfc_stop_last = ULFC_OS_STOP2;
	endfunction

endpackage
`default_nettype wire

/* File: verilog/ulfc_baud_tick.sv */
// 16x oversampling enable from the divisor value
// assumes the divisor comes from an external latch; 0 acts as 1
`default_nettype none
`timescale 1ns/10ps
module ulfc_baud_tick #(
	parameter int DIV_W = ulfc_pkg::ULFC_DIV_W
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [DIV_W-1:0] div_in,
	output logic tick_out
);
	import ulfc_pkg::*;

	logic [DIV_W-1:0] cnt;
	logic [DIV_W-1:0] next_cnt;

	assign next_cnt = cnt + {{(DIV_W-1){1'b0}}, 1'b1};

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= '0;
			tick_out <= 1'b0;
		end else if (next_cnt >= div_in) begin
			cnt <= '0;
			tick_out <= 1'b1;
		end else begin
			cnt <= next_cnt;
			tick_out <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: verilog/uart_line_format_control.sv */
// line format register with the transmit and receive framers it steers
// assumes a synchronous serial input and a divisor from outside
`default_nettype none
`timescale 1ns/10ps
// Behaviour
// - bit 7 opens divisor latch access
// - bit 6 holds transmit line low
// - bit 3 adds and checks parity
// - bit 4 picks even, else odd
// - bit 5 forces parity constant
// - bit 2 selects long transmit stop period; the receiver checks one stop bit
// - bits 1:0 give five to eight bits
module uart_line_format_control #(
	parameter int DIV_W = ulfc_pkg::ULFC_DIV_W
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic lfc_wr_in,
	input wire ulfc_pkg::ulfc_fmt_t lfc_wdata_in,
	output ulfc_pkg::ulfc_fmt_t lfc_rdata_out,
	output logic divisor_access_out,
	input wire logic [DIV_W-1:0] baud_div_in,
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_ready_out,
	output logic tx_out,
	input wire logic rx_in,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	output logic rx_parity_err_out,
	output logic rx_frame_err_out
);
	import ulfc_pkg::*;

	// -------------------------------------------------------------
	// format register
	// -------------------------------------------------------------
	ulfc_fmt_t lfc;
	logic tick;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			lfc <= ULFC_FMT_RESET;
		else if (lfc_wr_in)
			lfc <= lfc_wdata_in;
	end

	assign lfc_rdata_out = lfc;
	assign divisor_access_out = lfc.dlab;

	ulfc_baud_tick #(.DIV_W(DIV_W)) u_ulfc_baud_tick (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.div_in(baud_div_in),
		.tick_out(tick)
	);

	// -------------------------------------------------------------
	// transmit framer
	// -------------------------------------------------------------
	ulfc_state_t tx_state;
	ulfc_fmt_t tx_fmt;
	logic [5:0] tx_os;
	logic [2:0] tx_bit;
	logic [7:0] tx_shift;
	logic [7:0] tx_char;
	logic tx_par;
	logic tx_line;
	logic tx_end;

	always_comb begin
		if (tx_state == ST_STOP)
			tx_end = tick && (tx_os == ulfc_stop_last(tx_fmt));
		else
			tx_end = tick && (tx_os == ULFC_OS_LAST);
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_state <= ST_IDLE;
			tx_fmt <= ULFC_FMT_RESET;
			tx_os <= '0;
			tx_bit <= '0;
			tx_shift <= '0;
			tx_char <= '0;
			tx_par <= 1'b0;
			tx_line <= 1'b1;
			tx_ready_out <= 1'b1;
		end else if (tx_state == ST_IDLE) begin
			if (tx_valid_in && tx_ready_out) begin
				tx_state <= ST_START;
				tx_fmt <= lfc;
				tx_shift <= tx_data_in;
				tx_char <= tx_data_in;
				tx_par <= ulfc_parity(lfc, tx_data_in);
				tx_os <= '0;
				tx_line <= 1'b0;
				tx_ready_out <= 1'b0;
			end
		end else if (tick) begin
			tx_os <= tx_end ? 6'h00 : tx_os + 6'h01;
			if (tx_end) begin
				unique case (tx_state)
				ST_START: begin
					tx_state <= ST_DATA;
					tx_bit <= '0;
					tx_line <= tx_shift[0];
				end
				ST_DATA: begin
					if (tx_bit == ulfc_last_bit(tx_fmt.wlen)) begin
						if (tx_fmt.par_en) begin
							tx_state <= ST_PARITY;
							tx_line <= tx_par;
						end else begin
							tx_state <= ST_STOP;
							tx_line <= 1'b1;
						end
					end else begin
						tx_bit <= tx_bit + 3'h1;
						tx_shift <= tx_shift >> 1;
						tx_line <= tx_shift[1];
					end
				end
				ST_PARITY: begin
					tx_state <= ST_STOP;
					tx_line <= 1'b1;
				end
				ST_STOP: begin
					tx_state <= ST_IDLE;
					tx_ready_out <= 1'b1;
				end
				default: tx_state <= ST_IDLE;
				endcase
			end
		end
	end

	// break overrides the line at once, without waiting for a frame end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			tx_out <= 1'b1;
		else
			tx_out <= tx_line && !lfc.brk;
	end

	// -------------------------------------------------------------
	// receive framer
	// -------------------------------------------------------------
	ulfc_state_t rx_state;
	ulfc_fmt_t rx_fmt;
	logic [5:0] rx_os;
	logic [2:0] rx_bit;
	logic [7:0] rx_shift;
	logic rx_perr;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_state <= ST_IDLE;
			rx_fmt <= ULFC_FMT_RESET;
			rx_os <= '0;
			rx_bit <= '0;
			rx_shift <= '0;
			rx_perr <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_data_out <= '0;
			rx_parity_err_out <= 1'b0;
			rx_frame_err_out <= 1'b0;
		end else begin
			rx_valid_out <= 1'b0;
			if (tick) begin
				rx_os <= rx_os + 6'h01;
				unique case (rx_state)
				ST_IDLE: begin
					rx_os <= '0;
					if (!rx_in) begin
						rx_state <= ST_START;
						rx_fmt <= lfc;
						rx_shift <= '0;
						rx_perr <= 1'b0;
					end
				end
				ST_START: begin
					if (rx_os == ULFC_OS_MID) begin
						rx_os <= '0;
						rx_bit <= '0;
						rx_state <= rx_in ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (rx_os == ULFC_OS_LAST) begin
						rx_os <= '0;
						rx_shift[rx_bit] <= rx_in;
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == ulfc_last_bit(rx_fmt.wlen))
							rx_state <= rx_fmt.par_en ? ST_PARITY : ST_STOP;
					end
				end
				ST_PARITY: begin
					if (rx_os == ULFC_OS_LAST) begin
						rx_os <= '0;
						rx_perr <= rx_in != ulfc_parity(rx_fmt, rx_shift);
						rx_state <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (rx_os == ULFC_OS_LAST) begin
						rx_os <= '0;
						rx_state <= ST_IDLE;
						rx_valid_out <= 1'b1;
						rx_data_out <= rx_shift;
						rx_parity_err_out <= rx_perr;
						rx_frame_err_out <= !rx_in;
					end
				end
				default: rx_state <= ST_IDLE;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	a_dlab_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		lfc_wr_in |=> divisor_access_out == $past(lfc_wdata_in.dlab))
		else $error("divisor access does not follow write");
	a_break_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		lfc.brk |=> !tx_out)
		else $error("break set but line not low");
	a_parity_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(tx_state == ST_PARITY || rx_state == ST_PARITY) |->
		(tx_state != ST_PARITY || tx_fmt.par_en) &&
		(rx_state != ST_PARITY || rx_fmt.par_en))
		else $error("parity slot without parity enabled");
	a_parity_sense: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(tx_state == ST_PARITY && !tx_fmt.force_par) |->
		tx_line == (tx_fmt.even ? ^(tx_char & (8'hff >> (3'h3 -
		{1'b0, tx_fmt.wlen}))) : ~^(tx_char & (8'hff >> (3'h3 -
		{1'b0, tx_fmt.wlen})))))
		else $error("wrong parity sense");
	a_parity_force: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(tx_state == ST_PARITY && tx_fmt.force_par) |->
		tx_line == !tx_fmt.even)
		else $error("forced parity wrong");
	a_stop_len: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(tx_state == ST_STOP) |-> tx_line &&
		tx_os <= (!tx_fmt.stop_long ? 6'h0f :
		(tx_fmt.wlen == 2'h0 ? 6'h17 : 6'h1f)))
		else $error("stop period too long or not high");
	a_word_len: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(tx_state == ST_DATA) |-> tx_bit <= 3'h4 + {1'b0, tx_fmt.wlen})
		else $error("data bit past word length");
	a_fmt_stable: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(tx_state != ST_IDLE && $past(tx_state) != ST_IDLE) |->
		$stable(tx_fmt))
		else $error("format changed mid frame");

endmodule
`default_nettype wire

/* File: verification/ulfc_remote_term.sv */
// remote serial terminal model: sends frames, decodes frames
// assumes one bit time is 16 clocks (divisor of 1)
`default_nettype none
`timescale 1ns/10ps
module ulfc_remote_term (
	input wire logic clk_in,
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;

	// one bit for a full bit time
	task put(input logic b);
		line_out <= b;
		repeat (16) @(posedge clk_in);
	endtask

	// lsb first, optional parity, one stop bit of level sv
	task send(input logic [7:0] d, input int n, input logic pe, p, sv);
		@(posedge clk_in);
		put(1'b0);
		for (int i = 0; i < n; i++) put(d[i]);
		if (pe) put(p);
		put(sv);
		line_out <= 1'b1;
	endtask

	// samples each bit in its middle
	task grab(input int n, input logic pe, output logic [7:0] d,
			output logic p);
		d = 8'h00;
		p = 1'b0;
		@(posedge clk_in iff line_in === 1'b0);
		repeat (8) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			repeat (16) @(posedge clk_in);
			d[i] = line_in;
		end
		if (pe) begin
			repeat (16) @(posedge clk_in);
			p = line_in;
		end
	endtask
endmodule
`default_nettype wire

/* File: verification/uart_line_format_control_bench.sv */
// self-checking bench for the line format control block
// assumes divisor 1, so one bit time is 16 clocks
`default_nettype none
`timescale 1ns/10ps
module uart_line_format_control_bench;
	import ulfc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, tx_valid = 1'b0;
	logic div_acc, tx_ready, tx_line, rx_line, rx_valid, perr, ferr;
	logic [7:0] tx_data = 8'h00, rx_data;
	ulfc_fmt_t wdata = 8'h00, rdata;
	int bad_count = 0, total_checks = 0, cycles = 0;
	logic [7:0] fmts [9] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07,
		8'h0b, 8'h1b, 8'h2b, 8'h3b};

	uart_line_format_control u_uart_line_format_control (
		.ref_clk_in(clk), .rst_in(rst), .lfc_wr_in(wr),
		.lfc_wdata_in(wdata), .lfc_rdata_out(rdata),
		.divisor_access_out(div_acc), .baud_div_in(16'h0001),
		.tx_valid_in(tx_valid), .tx_data_in(tx_data),
		.tx_ready_out(tx_ready), .tx_out(tx_line), .rx_in(rx_line),
		.rx_valid_out(rx_valid), .rx_data_out(rx_data),
		.rx_parity_err_out(perr), .rx_frame_err_out(ferr));
	ulfc_remote_term u_ulfc_remote_term (
		.clk_in(clk), .line_in(tx_line), .line_out(rx_line));

	initial forever #4 clk = ~clk;

	// ----
	// helpers
	// ----
	task chk(input string nm, input logic [7:0] s, e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function logic [7:0] wmask(input logic [7:0] f, d);
		return d & ~(8'hff << (5 + f[1:0]));
	endfunction
	function logic parb(input logic [7:0] f, d);
		if (f[5])
			return ~f[4];
		return f[4] ? ^wmask(f, d) : ~^wmask(f, d);
	endfunction
	task wr_fmt(input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// ----
	// scenarios
	// ----
	task tx_char(input logic [7:0] f, d);
		logic [7:0] got;
		logic p;
		int cnt, len;
		cnt = 0;
		len = 2 * (6 + f[1:0] + f[3]) + (f[2] ? (f[1:0] == 0 ? 3 : 4) : 2);
		@(posedge clk);
		tx_valid <= 1'b1;
		tx_data <= d;
		@(posedge clk);
		tx_valid <= 1'b0;
		fork
			u_ulfc_remote_term.grab(5 + f[1:0], f[3], got, p);
			begin
				#1;
				while (tx_ready !== 1'b1 && cnt < 400) begin
					@(posedge clk);
					#1;
					cnt++;
				end
			end
		join
		chk("tx data", got, wmask(f, d));
		chk("tx parity", {7'h00, p}, {7'h00, f[3] & parb(f, d)});
		chk("tx length", 8'((cnt + 4) / 8), 8'(len));
		chk("tx ready", {7'h00, tx_ready}, 8'h01);
	endtask
	task rx_char(input logic [7:0] f, d, input logic bp, bs);
		int cnt;
		logic v;
		cnt = 0;
		v = 1'b0;
		fork
			u_ulfc_remote_term.send(d, 5 + f[1:0], f[3], parb(f, d) ^ bp, ~bs);
			begin
				while (rx_valid !== 1'b1 && cnt < 400) begin
					@(posedge clk);
					#1;
					cnt++;
				end
				v = rx_valid;
			end
		join
		chk("rx valid", {7'h00, v}, 8'h01);
		chk("rx data", rx_data, wmask(f, d));
		chk("rx parity err", {7'h00, perr}, {7'h00, f[3] & bp});
		chk("rx frame err", {7'h00, ferr}, {7'h00, bs});
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end

	task reg_scn();
		chk("reset value", rdata, 8'h00);
		wr_fmt(8'h83);
		chk("divisor access", {7'h00, div_acc}, 8'h01);
		chk("register", rdata, 8'h83);
	endtask
	task break_scn();
		wr_fmt(8'h43);
		chk("divisor access", {7'h00, div_acc}, 8'h00);
		@(posedge clk);
		#1;
		chk("break", {7'h00, tx_line}, 8'h00);
		repeat (60) @(posedge clk);
		#1;
		chk("break held", {7'h00, tx_line}, 8'h00);
		wr_fmt(8'h03);
		@(posedge clk);
		#1;
		chk("break off", {7'h00, tx_line}, 8'h01);
	endtask
	// format written mid frame must not touch the frame in flight
	task change_scn();
		fork
			tx_char(8'h03, 8'hc3);
			begin
				repeat (40) @(posedge clk);
				wr_fmt(8'h1c);
			end
		join
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		reg_scn();
		break_scn();
		for (int i = 0; i < 9; i++) begin
			wr_fmt(fmts[i]);
			tx_char(fmts[i], 8'hb6 ^ 8'(i));
			rx_char(fmts[i], 8'h5a + 8'(i), 1'b0, 1'b0);
		end
		rx_char(8'h3b, 8'h3c, 1'b1, 1'b0);
		wr_fmt(8'h0b);
		rx_char(8'h0b, 8'h3c, 1'b1, 1'b0);
		wr_fmt(8'h03);
		rx_char(8'h03, 8'h81, 1'b0, 1'b1);
		change_scn();
		close_out();
	end
endmodule
`default_nettype wire
